// ==== hdl/rfd_pkg.sv ====
package rfd_pkg;

    // Request field widths and the slice of the address that carries the identity.
    localparam int ADR_W = 36;
    localparam int CNT_W = 8;
    localparam int ID_W = 15;
    localparam int ID_LSB = 21;
    localparam int CNT_VAL_W = 16;

    // Register port: byte offsets of 32-bit words.
    localparam int RA_W = 5;
    localparam logic [RA_W-1:0] OFS_DEV_ID = 5'h00;
    localparam logic [RA_W-1:0] OFS_CTRL = 5'h04;
    localparam logic [RA_W-1:0] OFS_VERSION = 5'h08;
    localparam logic [RA_W-1:0] OFS_STATUS = 5'h0C;
    localparam logic [RA_W-1:0] OFS_ACC_CNT = 5'h10;
    localparam logic [RA_W-1:0] OFS_RETRY_CNT = 5'h14;

    // Field positions and reset values.
    localparam int CTRL_RESP_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACK_LSB = 1;
    localparam int STAT_RSVD_BIT = 3;
    localparam int STAT_REGLOW_BIT = 4;
    localparam int STAT_ROWX_BIT = 5;
    localparam logic [ID_W-1:0] DEV_ID_RST = 15'h0000;
    localparam logic CTRL_RESP_RST = 1'b1;
    // Arbitrary neutral protocol version value.
    localparam logic [7:0] VERSION_DEF = 8'h01;

    // Acknowledge codes; the fourth combination is never produced.
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_OKAY = 2'h1;
    localparam logic [1:0] ACK_RETRY = 2'h2;

    // Opcode groups (bit 0 of the memory groups selects the alternate set).
    localparam logic [3:0] OP_MRD = 4'h0;
    localparam logic [3:0] OP_WSEQ = 4'h4;
    localparam logic [3:0] OP_RREG = 4'h6;
    localparam logic [3:0] OP_WREG = 4'h7;
    localparam logic [3:0] OP_WNSQ = 4'h8;
    localparam logic [3:0] OP_WBNS = 4'hC;
    localparam logic [3:0] OP_BROADCAST_REGISTER_WRITE = 4'hF;
    localparam logic [1:0] OPX_PLAIN = 2'h0;
    localparam logic [1:0] OPX_RNSQ = 2'h1;
    localparam logic [1:0] OPX_BPB = 2'h2;

    // Masks and octbyte arithmetic.
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [4:0] CV_ONE = 5'h00;
    localparam logic [5:0] ROW_OCTS = 6'h20;
    localparam logic [7:0] ROW_LAST_OCT = 8'hFF;

    typedef enum logic [2:0] {
        RFD_K_NONE,
        RFD_K_MRD,
        RFD_K_MWSEQ,
        RFD_K_MWNSQ,
        RFD_K_MWBNS,
        RFD_K_RRD,
        RFD_K_RWR,
        RFD_K_RWB
    } rfd_kind_t;

    typedef enum logic {
        RFD_S_IDLE,
        RFD_S_ACCESS
    } rfd_state_t;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] opx;
        logic [ADR_W-1:0] adr;
        logic [CNT_W-1:0] count;
        logic close;
        logic [7:0] reserved_request_bits;
    } rfd_req_t;

    typedef struct packed {
        logic post_write;
        logic row_miss;
        logic refresh;
    } rfd_cause_t;

    typedef struct packed {
        rfd_kind_t kind;
        logic alt;
        logic nsq_read;
        logic [1:0] bitmask_mode;
        logic [33:0] quad_adr;
        logic [32:0] oct_adr;
        logic [5:0] units;
        logic [2:0] mask_octs;
        logic [7:0] first_octbyte_mask;
        logic [7:0] last_octbyte_mask;
        logic [7:0] single_mask;
        logic close;
    } rfd_cmd_t;

endpackage

// ==== hdl/rfd_mask_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module rfd_mask_gen (
    // Low address and count bits.
    input wire logic [2:0] adr_low_i,
    input wire logic [2:0] cnt_low_i,
    input wire logic single_i,
    // Derived masks.
    output logic [7:0] first_o,
    output logic [7:0] last_o,
    output logic [7:0] eff_o
);

    // Sets bits 0 through k.
    function automatic logic [7:0] fill_low(input logic [2:0] k);
        fill_low = 8'hFF >> (3'h7 - k);
    endfunction

    always_comb begin
        first_o = ~(fill_low(adr_low_i) >> 1);
        last_o = fill_low(cnt_low_i);
        eff_o = single_i ? (first_o & last_o) : first_o;
    end

endmodule

`default_nettype wire

// ==== hdl/rfd_request_decode.sv ====
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Memory and register read/write proceed only when address identity slice matches.
// - Broadcast register write is carried out by every device, identity ignored.
// - Register commands use address bits 35:2 as a quadbyte address.
// - Memory commands use address bits 35:3 as an octbyte address.
// - Register reads and writes move exactly one quadbyte, count ignored.
// - Memory count bits 7:3 give octbytes minus one, 1 to 32.
// - Count includes both-per-bit mask octbytes, excludes scattered byte-mask octbytes.
// - Memory reads return all bytes of first and last octbytes.
// - Sequential writes mask first and last octbytes; middle octbytes write every byte.
// - With a one-octbyte count the effective mask is first AND last.
// - First mask sets bits k to 7 from low address value k.
// - Last mask sets bits 0 to k from low count value k.
// - Close set restores a dirty open row after the access; clear leaves it.
// - Reserved bits are ignored; decoding uses only the defined fields.
// - Acknowledge: 00 none, 01 accepted, 10 retry; 11 is never sent.
// - Retry changes no state, prepares the region; initiator reissues later.
// - Broadcast register write answers 00 or retry, never accepted.
module rfd_request_decode #(
    parameter logic [7:0] VERSION = rfd_pkg::VERSION_DEF
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Request packet fields.
    input wire logic req_valid_i,
    input wire rfd_pkg::rfd_req_t req_i,
    // Core conditions forcing a retry.
    input wire rfd_pkg::rfd_cause_t cause_i,
    // Core access completion and bank dirty flag.
    input wire logic access_done_i,
    input wire logic bank_dirty_i,
    // Acknowledge.
    output logic ack_valid_o,
    output logic [1:0] ack_o,
    // Decoded command to the core.
    output logic cmd_valid_o,
    output rfd_pkg::rfd_cmd_t cmd_o,
    // Row restore and retry preparation.
    output logic restore_o,
    output logic prepare_o,
    output rfd_pkg::rfd_cause_t prepare_cause_o,
    // Register port.
    input wire logic [rfd_pkg::RA_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import rfd_pkg::*;

    typedef struct packed {
        rfd_state_t st;
        logic [ID_W-1:0] device_identifier_reg;
        logic resp_en;
        logic ack_vld;
        logic [1:0] ack;
        logic [1:0] last_ack;
        logic cmd_vld;
        rfd_cmd_t cmd;
        logic close_pend;
        logic restore;
        logic prepare;
        rfd_cause_t cause;
        logic rsvd_seen;
        logic reg_low_seen;
        logic row_cross_seen;
        logic [CNT_VAL_W-1:0] acc_cnt;
        logic [CNT_VAL_W-1:0] retry_cnt;
        logic [31:0] rdata;
    } rfd_regs_t;

    rfd_regs_t q;
    rfd_regs_t d;

    rfd_kind_t kind;
    logic identity_match;
    logic targeted;
    logic is_mem;
    logic is_reg;
    logic busy;
    logic single;
    logic [4:0] cv;
    logic [7:0] gen_first;
    logic [7:0] gen_last;
    logic [7:0] gen_eff;
    logic [8:0] row_end;
    logic [31:0] status_word;
    rfd_cmd_t cmd;

    // Reserved bits take no part in this decode.
    function automatic rfd_kind_t decode_kind(
        input logic [3:0] op,
        input logic [1:0] opx
    );
        logic [3:0] grp;
        grp = {op[3:1], 1'b0};
        decode_kind = RFD_K_NONE;
        if (grp == OP_MRD && opx[1] == 1'b0) begin
            decode_kind = RFD_K_MRD;
        end else if (grp == OP_WSEQ) begin
            decode_kind = RFD_K_MWSEQ;
        end else if (grp == OP_WNSQ) begin
            decode_kind = RFD_K_MWNSQ;
        end else if (grp == OP_WBNS && opx != OPX_BPB) begin
            decode_kind = RFD_K_MWBNS;
        end else if (op == OP_RREG && opx == OPX_PLAIN) begin
            decode_kind = RFD_K_RRD;
        end else if (op == OP_WREG && opx == OPX_PLAIN) begin
            decode_kind = RFD_K_RWR;
        end else if (op == OP_BROADCAST_REGISTER_WRITE && opx == OPX_PLAIN) begin
            decode_kind = RFD_K_RWB;
        end
    endfunction

    rfd_mask_gen u_mask (
        .adr_low_i(req_i.adr[2:0]),
        .cnt_low_i(req_i.count[2:0]),
        .single_i(single),
        .first_o(gen_first),
        .last_o(gen_last),
        .eff_o(gen_eff)
    );

    always_comb begin
        kind = decode_kind(req_i.op, req_i.opx);
        identity_match = (req_i.adr[ID_LSB +: ID_W] == q.device_identifier_reg);
        is_mem = (kind == RFD_K_MRD) || (kind == RFD_K_MWSEQ)
            || (kind == RFD_K_MWNSQ) || (kind == RFD_K_MWBNS);
        is_reg = (kind == RFD_K_RRD) || (kind == RFD_K_RWR) || (kind == RFD_K_RWB);
        // Broadcast writes skip the identity check.
        targeted = q.resp_en && ((kind == RFD_K_RWB)
            || (kind != RFD_K_NONE && identity_match));
        busy = cause_i.post_write || cause_i.row_miss || cause_i.refresh
            || (q.st == RFD_S_ACCESS);
        cv = req_i.count[7:3];
        single = (cv == CV_ONE);
        // Octbyte index of the last octbyte inside its 2 kilobyte row.
        row_end = {1'b0, req_i.adr[10:3]} + {4'h0, cv};
    end

    always_comb begin
        cmd = '0;
        cmd.kind = kind;
        cmd.alt = is_mem ? req_i.op[0] : 1'b0;
        cmd.nsq_read = (kind == RFD_K_MRD) && (req_i.opx == OPX_RNSQ);
        cmd.bitmask_mode = (is_mem && kind != RFD_K_MRD) ? req_i.opx : 2'h0;
        cmd.quad_adr = req_i.adr[35:2];
        cmd.oct_adr = req_i.adr[35:3];
        cmd.first_octbyte_mask = MASK_ALL;
        cmd.last_octbyte_mask = MASK_ALL;
        cmd.single_mask = MASK_ALL;
        cmd.mask_octs = 3'h0;
        cmd.close = 1'b0;
        if (is_reg) begin
            cmd.units = 6'h01;
        end else begin
            // Both-per-bit mask octbytes sit inside this count.
            cmd.units = {1'b0, cv} + 6'h01;
            cmd.close = req_i.close;
        end
        if (kind == RFD_K_MWBNS) begin
            // One byte-mask octbyte per eight data octbytes, outside the count.
            cmd.mask_octs = {1'b0, cv[4:3]} + 3'h1;
        end
        if (kind == RFD_K_MWSEQ) begin
            // Middle octbytes always use the full mask.
            cmd.first_octbyte_mask = gen_first;
            cmd.last_octbyte_mask = gen_last;
            cmd.single_mask = gen_eff;
        end
        // Reads keep full masks so every byte comes back.
        if (kind == RFD_K_MRD) begin
            cmd.single_mask = MASK_ALL;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_BUSY_BIT] = (q.st == RFD_S_ACCESS);
        status_word[STAT_ACK_LSB +: 2] = q.last_ack;
        status_word[STAT_RSVD_BIT] = q.rsvd_seen;
        status_word[STAT_REGLOW_BIT] = q.reg_low_seen;
        status_word[STAT_ROWX_BIT] = q.row_cross_seen;
    end

    always_comb begin
        d = q;
        d.ack_vld = 1'b0;
        d.ack = ACK_NONE;
        d.cmd_vld = 1'b0;
        d.restore = 1'b0;
        d.prepare = 1'b0;
        d.rdata = 32'h0000_0000;

        // Software write-one-to-clear of the observation flags; a new event wins below.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_DEV_ID: begin
                    d.device_identifier_reg = reg_wdata_i[ID_W-1:0];
                end
                OFS_CTRL: begin
                    d.resp_en = reg_wdata_i[CTRL_RESP_BIT];
                end
                OFS_STATUS: begin
                    d.rsvd_seen = q.rsvd_seen & ~reg_wdata_i[STAT_RSVD_BIT];
                    d.reg_low_seen = q.reg_low_seen & ~reg_wdata_i[STAT_REGLOW_BIT];
                    d.row_cross_seen = q.row_cross_seen & ~reg_wdata_i[STAT_ROWX_BIT];
                end
                default: begin
                end
            endcase
        end

        // Access in progress: the open row is restored only if close was asked.
        if (q.st == RFD_S_ACCESS && access_done_i) begin
            d.st = RFD_S_IDLE;
            d.restore = q.close_pend && bank_dirty_i;
            d.close_pend = 1'b0;
        end

        if (req_valid_i) begin
            d.ack_vld = 1'b1;
            d.ack = ACK_NONE;
            if (targeted) begin
                if (req_i.reserved_request_bits != 8'h00) begin
                    d.rsvd_seen = 1'b1;
                end
                if (is_reg && req_i.adr[1:0] != 2'b00) begin
                    d.reg_low_seen = 1'b1;
                end
                if (is_mem && row_end > {1'b0, ROW_LAST_OCT}) begin
                    d.row_cross_seen = 1'b1;
                end
                if (busy) begin
                    // Nothing reaches the core; it is only told to get ready.
                    d.ack = ACK_RETRY;
                    d.prepare = 1'b1;
                    d.cause = cause_i;
                    d.retry_cnt = q.retry_cnt + 16'h0001;
                end else begin
                    d.ack = (kind == RFD_K_RWB) ? ACK_NONE : ACK_OKAY;
                    d.cmd_vld = 1'b1;
                    d.cmd = cmd;
                    d.acc_cnt = q.acc_cnt + 16'h0001;
                    if (is_mem) begin
                        d.st = RFD_S_ACCESS;
                        d.close_pend = req_i.close;
                    end
                end
            end
            d.last_ack = d.ack;
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_DEV_ID: begin
                    d.rdata = {{(32-ID_W){1'b0}}, q.device_identifier_reg};
                end
                OFS_CTRL: begin
                    d.rdata = {31'h0000_0000, q.resp_en};
                end
                OFS_VERSION: begin
                    d.rdata = {24'h00_0000, VERSION};
                end
                OFS_STATUS: begin
                    d.rdata = status_word;
                end
                OFS_ACC_CNT: begin
                    d.rdata = {16'h0000, q.acc_cnt};
                end
                OFS_RETRY_CNT: begin
                    d.rdata = {16'h0000, q.retry_cnt};
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // The whole state resets together so the port never shows a stale answer.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= RFD_S_IDLE;
            q.device_identifier_reg <= DEV_ID_RST;
            q.resp_en <= CTRL_RESP_RST;
            q.ack <= ACK_NONE;
            q.last_ack <= ACK_NONE;
        end else begin
            q <= d;
        end
    end

    assign ack_valid_o = q.ack_vld;
    assign ack_o = q.ack;
    assign cmd_valid_o = q.cmd_vld;
    assign cmd_o = q.cmd;
    assign restore_o = q.restore;
    assign prepare_o = q.prepare;
    assign prepare_cause_o = q.cause;
    assign reg_rdata_o = q.rdata;

endmodule

`default_nettype wire

// ==== tb/rfd_request_decode_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfd_request_decode_assertions (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Request.
    input wire logic req_valid_i,
    input wire rfd_pkg::rfd_req_t req_i,
    input wire rfd_pkg::rfd_cause_t cause_i,
    input wire logic access_done_i,
    input wire logic bank_dirty_i,
    // Answer.
    input wire logic ack_valid_o,
    input wire logic [1:0] ack_o,
    input wire logic cmd_valid_o,
    input wire rfd_pkg::rfd_cmd_t cmd_o,
    input wire logic restore_o,
    input wire logic prepare_o
);
    import rfd_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic is_reg;
    logic is_seq;
    assign is_reg = cmd_valid_o && cmd_o.kind inside {RFD_K_RRD, RFD_K_RWR, RFD_K_RWB};
    assign is_seq = cmd_valid_o && cmd_o.kind == RFD_K_MWSEQ;
    property p_code;
        ack_valid_o |-> ack_o != 2'h3;
    endproperty
    a_code: assert property (p_code) else $error("ack code 11 seen");
    property p_answer;
        ack_valid_o == $past(req_valid_i);
    endproperty
    a_answer: assert property (p_answer) else $error("ack not one cycle after request");
    property p_retry;
        req_valid_i && (|cause_i) |=> ack_o == ACK_RETRY && prepare_o && !cmd_valid_o;
    endproperty
    a_retry: assert property (p_retry) else $error("busy cause not retried");
    property p_hold;
        prepare_o |-> $stable(cmd_o);
    endproperty
    a_hold: assert property (p_hold) else $error("command changed on retry");
    property p_bcast;
        cmd_valid_o && cmd_o.kind == RFD_K_RWB |-> ack_o == ACK_NONE;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast not answered 00");
    property p_reg;
        is_reg |-> cmd_o.units == 6'h01 && cmd_o.quad_adr == $past(req_i.adr[35:2]);
    endproperty
    a_reg: assert property (p_reg) else $error("register command size or address");
    property p_mem;
        cmd_valid_o && !is_reg |-> cmd_o.units == {1'b0, $past(req_i.count[7:3])} + 6'h01
            && cmd_o.oct_adr == $past(req_i.adr[35:3]);
    endproperty
    a_mem: assert property (p_mem) else $error("memory command size or address");
    property p_mask;
        is_seq |-> cmd_o.first_octbyte_mask == 8'(MASK_ALL << $past(req_i.adr[2:0]))
            && cmd_o.last_octbyte_mask == 8'(MASK_ALL >> (3'h7 - $past(req_i.count[2:0])));
    endproperty
    a_mask: assert property (p_mask) else $error("first or last mask wrong");
    property p_single;
        is_seq && cmd_o.units == 6'h01 |->
            cmd_o.single_mask == (cmd_o.first_octbyte_mask & cmd_o.last_octbyte_mask);
    endproperty
    a_single: assert property (p_single) else $error("single octbyte mask wrong");
    property p_read;
        cmd_valid_o && cmd_o.kind == RFD_K_MRD |-> (cmd_o.first_octbyte_mask
            & cmd_o.last_octbyte_mask & cmd_o.single_mask) == MASK_ALL;
    endproperty
    a_read: assert property (p_read) else $error("read masks not all ones");
    property p_restore;
        restore_o |-> $past(access_done_i && bank_dirty_i);
    endproperty
    a_restore: assert property (p_restore) else $error("restore without dirty done");
    property p_clean;
        !bank_dirty_i |=> !restore_o;
    endproperty
    a_clean: assert property (p_clean) else $error("restore of clean row");
    c_retry: cover property (prepare_o);
    c_restore: cover property (restore_o);
    c_bcast: cover property (cmd_valid_o && cmd_o.kind == RFD_K_RWB);
endmodule
bind rfd_request_decode rfd_request_decode_assertions u_chk (.sys_clk_i, .rst_n_i,
    .req_valid_i, .req_i, .cause_i, .access_done_i, .bank_dirty_i, .ack_valid_o, .ack_o,
    .cmd_valid_o, .cmd_o, .restore_o, .prepare_o);
`default_nettype wire

// ==== tb/rfd_initiator_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfd_initiator_model (
    // Clock.
    input wire logic sys_clk_i,
    // Request out.
    output logic req_valid_o,
    output rfd_pkg::rfd_req_t req_o,
    // Acknowledge in.
    input wire logic ack_valid_i,
    input wire logic [1:0] ack_i
);
    import rfd_pkg::*;
    logic [1:0] last_ack;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // A retried request is sent again after a pause; 11 marks a missing answer.
    task automatic send(input rfd_req_t r, input int tries);
        for (int t = 0; t < tries; t++) begin
            @(posedge sys_clk_i);
            req_valid_o <= 1'b1;
            req_o <= r;
            @(posedge sys_clk_i);
            req_valid_o <= 1'b0;
            req_o <= ~r;
            #1;
            last_ack = ack_valid_i ? ack_i : 2'h3;
            // The last try returns at once so that its one-cycle answers can still be seen.
            if (last_ack != ACK_RETRY || t == tries - 1) break;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask
    task automatic issue(input logic [3:0] op, input logic [35:0] adr, input logic [7:0] mc,
                         input logic close, input logic bad, input int tries);
        rfd_req_t r;
        logic [8:0] sum;
        sum = {6'h00, adr[2:0]} + {1'b0, mc};
        r = '{op: op, opx: OPX_PLAIN, adr: adr, count: mc, close: close,
              reserved_request_bits: (bad ? 8'hA5 : 8'h00)};
        if (op inside {OP_RREG, OP_WREG, OP_BROADCAST_REGISTER_WRITE}) begin
            r.adr[1:0] = 2'h0;
        end else if (op[3:1] == 3'h0 || op[3:1] == 3'h2) begin
            r.count = sum[7:0];
            if (sum[8]) begin
                r.count = 8'hFF;
                send(r, tries);
                r.adr = {adr[35:3], 3'h0} + 36'h100;
                r.count = sum[7:0];
            end
        end
        send(r, tries);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rfd_pkg::*;
    logic sys_clk_i, rst_n_i, req_valid, done, dirty, ack_valid, cmd_valid, restore, prepare;
    logic reg_wr, reg_rd;
    logic [1:0] ack;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    rfd_req_t req;
    rfd_cause_t cause, prep_cause;
    rfd_cmd_t cmd;
    rfd_cmd_t cq[$];
    int err_count, cmp_count, cyc;
    rfd_request_decode dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
        .req_i(req), .cause_i(cause), .access_done_i(done), .bank_dirty_i(dirty),
        .ack_valid_o(ack_valid), .ack_o(ack), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .restore_o(restore), .prepare_o(prepare), .prepare_cause_o(prep_cause),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata));
    rfd_initiator_model ini (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid), .req_o(req),
        .ack_valid_i(ack_valid), .ack_i(ack));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (cmd_valid) cq.push_back(cmd);
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        #1;
        chk("reg read", reg_rdata, exp);
    endtask
    task automatic t_regs();
        rd(OFS_VERSION, {24'h0, VERSION_DEF});
        rd(OFS_CTRL, 32'h1);
        rd(OFS_DEV_ID, 32'h0);
        wr(OFS_VERSION, 32'hFF);
        rd(OFS_VERSION, {24'h0, VERSION_DEF});
        rd(5'h1C, 32'h0);
    endtask
    // Odd steps carry nonzero reserved bits, which must change nothing but the reserved-bits status flag.
    task automatic t_masks();
        logic [7:0] f, l;
        for (int k = 0; k < 8; k++) begin
            f = 8'hFF << k;
            l = 8'hFF >> (7 - k);
            ini.issue(OP_WSEQ, 36'h40 + 36'(k), 8'h00, 1'b0, k[0], 1);
            chk("ack", ini.last_ack, ACK_OKAY);
            chk("first", cmd.first_octbyte_mask, f);
            chk("last", cmd.last_octbyte_mask, l);
            chk("single", cmd.single_mask, f & l);
        end
        ini.issue(OP_MRD, 36'h43, 8'h02, 1'b0, 1'b0, 1);
        chk("read masks", {cmd.first_octbyte_mask, cmd.last_octbyte_mask}, 16'hFFFF);
        // Reserved bits were seen, last answer accepted; nine commands accepted.
        rd(OFS_STATUS, 32'h0000_000A);
        wr(OFS_STATUS, 32'h0000_0008);
        rd(OFS_STATUS, 32'h0000_0002);
        rd(OFS_ACC_CNT, 32'h0000_0009);
    endtask
    task automatic t_kinds();
        logic [3:0] ops [6] = '{OP_MRD, OP_WSEQ, OP_WNSQ, OP_WBNS, OP_RREG, OP_WREG};
        rfd_kind_t kd [6] = '{RFD_K_MRD, RFD_K_MWSEQ, RFD_K_MWNSQ, RFD_K_MWBNS, RFD_K_RRD,
                              RFD_K_RWR};
        for (int i = 0; i < 6; i++) begin
            ini.issue(ops[i], 36'h0_0012_3458, 8'h28, 1'b0, 1'b0, 1);
            chk("kind", {cmd_valid, cmd.kind}, {1'b1, kd[i]});
            chk("units", cmd.units, (i < 4) ? 6'h06 : 6'h01);
            chk("mask octs", cmd.mask_octs, (i == 3) ? 3'h1 : 3'h0);
            chk("quad", cmd.quad_adr, 34'h4_8D16);
            chk("oct", cmd.oct_adr, 33'h2_468B);
        end
    endtask
    task automatic t_ident();
        ini.issue(OP_WSEQ, 36'h0_0020_0000, 8'h07, 1'b0, 1'b0, 1);
        chk("mismatch", {ini.last_ack, cmd_valid}, {ACK_NONE, 1'b0});
        ini.issue(OP_BROADCAST_REGISTER_WRITE, 36'h0_0020_0010, 8'h00, 1'b0, 1'b0, 1);
        chk("bcast ack", ini.last_ack, ACK_NONE);
        chk("bcast cmd", {cmd_valid, cmd.kind}, {1'b1, RFD_K_RWB});
        wr(OFS_DEV_ID, 32'h1);
        ini.issue(OP_WSEQ, 36'h0_0020_0000, 8'h07, 1'b0, 1'b0, 1);
        chk("match", ini.last_ack, ACK_OKAY);
        wr(OFS_DEV_ID, 32'h0);
    endtask
    task automatic t_retry();
        @(posedge sys_clk_i);
        cause <= 3'b010;
        ini.issue(OP_WSEQ, 36'h100, 8'h07, 1'b0, 1'b0, 1);
        chk("retry", {ini.last_ack, prepare, cmd_valid}, {ACK_RETRY, 2'b10});
        chk("cause", prep_cause, 3'b010);
        // The cause lasts past the first try so that the reissue is really exercised.
        fork
            ini.issue(OP_WSEQ, 36'h100, 8'h07, 1'b0, 1'b0, 4);
            begin
                repeat (3) @(posedge sys_clk_i);
                cause <= 3'b000;
            end
        join
        chk("reissue", ini.last_ack, ACK_OKAY);
    endtask
    // Access held open so that a second request meets a busy block.
    task automatic t_restore();
        for (int c = 1; c >= 0; c--) begin
            @(posedge sys_clk_i);
            done <= 1'b0;
            dirty <= 1'b1;
            ini.issue(OP_WSEQ, 36'h200, 8'h07, c[0], 1'b0, 1);
            chk("close", cmd.close, c[0]);
            ini.issue(OP_MRD, 36'h300, 8'h07, 1'b0, 1'b0, 1);
            chk("busy", ini.last_ack, ACK_RETRY);
            @(posedge sys_clk_i);
            done <= 1'b1;
            @(posedge sys_clk_i);
            done <= 1'b0;
            #1;
            chk("restore", restore, c[0]);
        end
        @(posedge sys_clk_i);
        done <= 1'b1;
        dirty <= 1'b0;
    endtask
    // Both halves stay inside one 2 kbyte row.
    task automatic t_split();
        cq.delete();
        ini.issue(OP_WSEQ, 36'h105, 8'hFE, 1'b0, 1'b0, 4);
        @(posedge sys_clk_i);
        #1;
        chk("parts", cq.size(), 2);
        chk("units", {cq[0].units, cq[1].units}, {6'h20, 6'h01});
        chk("second", cq[1].oct_adr, 33'h40);
        chk("masks", {cq[0].first_octbyte_mask, cq[1].last_octbyte_mask}, 16'hE00F);
        // Two retries in the retry scenario and two while an access was open.
        rd(OFS_RETRY_CNT, 32'h0000_0004);
    endtask
    initial begin
        rst_n_i = 1'b0;
        cause = 3'b000;
        done = 1'b1;
        dirty = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_masks();
        t_kinds();
        t_ident();
        t_retry();
        t_restore();
        t_split();
        results();
    end
endmodule
`default_nettype wire
